/* File: verilog/sfs_front_end.sv */
// sfs_front_end: serial link front end of a small serial flash
// assumes pins arrive asynchronously and the link clock is far below clk_sys
`timescale 1ns/1ps

module sfs_front_end
    import sfs_pkg::*;
#(
    parameter int         CHIP_CYC     = CYC_CHIP, // chip erase busy cycles
    parameter int         BLK_CYC      = CYC_BLK,  // sector/block busy cycles
    parameter logic [7:0] STATUS_WR_OP = 8'h01     // opcode of write_status_cmd
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        si,
    input  wire logic        hold_n,
    input  wire logic        wp_n,
    output logic             so,
    output logic             so_oe,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             irq
);
    sfs_pins_s         pin_raw;     // pins as they arrive
    sfs_pins_s         pin_m;       // first sync stage
    sfs_pins_s         pin_s;       // second sync stage
    logic              sck_d;       // previous synced clock
    logic              cs_d;        // previous synced select
    sfs_link_e         state;       // link state
    sfs_link_e         next_state;
    logic [6:0]        rx_sh;       // input shift register
    logic [2:0]        bit_cnt;     // bits of current byte
    logic [1:0]        byte_cnt;    // bytes of frame, saturating
    logic [7:0]        opcode;      // first byte of frame
    logic [7:0]        rx_data;
    logic [6:0]        tx_sh;       // output shift register
    logic [7:0]        tx_data;
    logic [7:0]        status;
    logic [1:0]        ctrl;
    logic [EV_W-1:0]   irq_st;
    logic [EV_W-1:0]   irq_mask;
    logic [ADR_W-1:0]  op_addr;     // base of last started op
    logic [CNT_W-1:0]  cnt;         // busy countdown

    // pin edges and qualifiers
    logic sck_rise, sck_fall, cs_fall, cs_rise, run, bit_take, byte_done;
    assign pin_raw   = '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};
    assign sck_rise  = pin_s.sck & ~sck_d;
    assign sck_fall  = ~pin_s.sck & sck_d;
    assign cs_fall   = cs_d & ~pin_s.cs_n;
    assign cs_rise   = ~cs_d & pin_s.cs_n;
    assign run       = (state == SFS_RUN) & ~pin_s.cs_n;
    assign bit_take  = run & sck_rise;
    assign byte_done = bit_take & (bit_cnt == 3'h7);

    // status write over the link, gated by the guard pin
    logic st_spi_wr, st_allow, st_refuse;
    assign st_spi_wr = byte_done & (byte_cnt == 2'h1) & (opcode == STATUS_WR_OP);
    assign st_allow  = pin_s.wp_n | ~status[ST_BPL];
    assign st_refuse = st_spi_wr & ~st_allow;

    // internal operation decode
    logic             cmd_wr, is_mem, prot_hit, op_go, op_refuse, op_done;
    logic [2:0]       cmd;
    logic [1:0]       lvl;
    logic [ADR_W-1:0] cmd_addr, op_mask, op_base;
    logic [CNT_W-1:0] op_cyc;
    assign cmd_wr   = wr & (addr == OFS_CMD);
    assign cmd      = wdata[2:0];
    assign cmd_addr = wdata[CMD_ADR_LSB +: ADR_W];
    assign is_mem   = (cmd != 3'h0) & (cmd < CMD_WREN);
    assign op_mask  = (cmd == CMD_SECT) ? MASK_4K :
                      (cmd == CMD_B32)  ? MASK_32K :
                      (cmd == CMD_B64)  ? MASK_64K : '0;
    assign op_base  = cmd_addr & ~op_mask;
    assign lvl      = status[ST_BP1:ST_BP0];
    assign prot_hit = (cmd == CMD_CHIP) ? (lvl != 2'h0) :
                      (lvl == 2'h3) | ((lvl == 2'h2) & op_base[17]) |
                      ((lvl == 2'h1) & (&op_base[17:16]));
    assign op_go     = cmd_wr & is_mem & ~status[ST_BUSY] & status[ST_WEL] & ~prot_hit;
    assign op_refuse = cmd_wr & is_mem & ~op_go;
    assign op_cyc    = (cmd == CMD_PROG) ? CNT_W'(CYC_PROG) :
                       (cmd == CMD_CHIP) ? CNT_W'(CHIP_CYC) : CNT_W'(BLK_CYC);
    assign op_done   = status[ST_BUSY] & (cnt == CNT_W'(1));

    // events and register read
    logic [EV_W-1:0] ev_set, ev_clr;
    logic [7:0]      stat_view;
    logic [31:0]     rd_word;
    assign ev_set    = {op_refuse, st_refuse, op_done, cs_rise, byte_done,
                        cs_fall & (state == SFS_IDLE)};
    assign ev_clr    = (rd & (addr == OFS_IRQ)) ? '1 : '0;
    assign stat_view = {status[7:7], ctrl[CT_AAI], 2'b00, status[3:0]};
    assign rd_word   = (addr == OFS_RXD)  ? {24'h00_0000, rx_data} :
                       (addr == OFS_TXD)  ? {24'h00_0000, tx_data} :
                       (addr == OFS_STAT) ? {24'h00_0000, stat_view} :
                       (addr == OFS_CTRL) ? {30'h0000_0000, ctrl} :
                       (addr == OFS_IRQ)  ? {26'h000_0000, irq_st} :
                       (addr == OFS_MASK) ? {26'h000_0000, irq_mask} :
                       (addr == OFS_BASE) ? {14'h0000, op_addr} :
                       (addr == OFS_LINK) ? {24'h00_0000, 1'b0, bit_cnt,
                                             byte_cnt, state} : '0;

    // link state: pause entry/exit only while clock low
    always_comb
    begin
        next_state = state;
        case (state)
            SFS_IDLE: if (cs_fall) next_state = SFS_RUN;
            SFS_RUN:
            begin
                if (pin_s.cs_n) next_state = SFS_IDLE;
                else if (~pin_s.sck & ~pin_s.hold_n) next_state = SFS_HOLD;
            end
            SFS_HOLD:
            begin
                if (pin_s.cs_n) next_state = SFS_IDLE;
                else if (~pin_s.sck & pin_s.hold_n) next_state = SFS_RUN;
            end
            default: next_state = SFS_IDLE;
        endcase
    end

    // two-stage pin synchroniser and edge history
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_m <= PIN_RESET;
            pin_s <= PIN_RESET;
            sck_d <= 1'b0;
            cs_d  <= 1'b1;
            state <= SFS_IDLE;
        end
        else
        begin
            pin_m <= pin_raw;
            pin_s <= pin_m;
            sck_d <= pin_s.sck;
            cs_d  <= pin_s.cs_n;
            state <= next_state;
        end
    end

    // input shifting; held in pause, dropped on new select
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rx_sh    <= '0;
            bit_cnt  <= '0;
            byte_cnt <= '0;
            opcode   <= '0;
            rx_data  <= '0;
        end
        else if (cs_fall)
        begin
            bit_cnt  <= '0;
            byte_cnt <= '0;
        end
        else if (bit_take)
        begin
            rx_sh   <= {rx_sh[5:0], pin_s.si};
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done)
            begin
                rx_data <= {rx_sh, pin_s.si};
                if (byte_cnt == 2'h0) opcode <= {rx_sh, pin_s.si};
                if (byte_cnt != 2'h3) byte_cnt <= byte_cnt + 2'h1;
            end
        end
    end

    // output shifting on falling clock; busy view in auto-increment mode
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            so    <= 1'b0;
            tx_sh <= '0;
            so_oe <= 1'b0;
        end
        else
        begin
            so_oe <= (next_state == SFS_RUN);
            if (run & sck_fall)
            begin
                if (ctrl[CT_AAI] & ctrl[CT_RBSO]) so <= ~status[ST_BUSY];
                else if (bit_cnt == 3'h0)
                begin
                    so    <= tx_data[7];
                    tx_sh <= tx_data[6:0];
                end
                else
                begin
                    so    <= tx_sh[6];
                    tx_sh <= {tx_sh[5:0], 1'b0};
                end
            end
        end
    end

    // status, busy timer and software registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            status   <= ST_RESET;
            cnt      <= '0;
            op_addr  <= '0;
            tx_data  <= '0;
            ctrl     <= '0;
            irq_mask <= '0;
        end
        else
        begin
            if (wr & (addr == OFS_TXD)) tx_data <= wdata[7:0];
            if (wr & (addr == OFS_CTRL)) ctrl <= wdata[1:0];
            if (wr & (addr == OFS_MASK)) irq_mask <= wdata[EV_W-1:0];
            if (op_go)
            begin
                status[ST_BUSY] <= 1'b1;
                cnt             <= op_cyc;
                op_addr         <= op_base;
            end
            else if (status[ST_BUSY])
            begin
                cnt <= cnt - CNT_W'(1);
                if (op_done)
                begin
                    status[ST_BUSY] <= 1'b0;
                    status[ST_WEL]  <= 1'b0;
                end
            end
            if (cmd_wr & (cmd == CMD_WREN) & ~status[ST_BUSY]) status[ST_WEL] <= 1'b1;
            if (cmd_wr & (cmd == CMD_WRDI)) status[ST_WEL] <= 1'b0;
            if (st_spi_wr & st_allow)
            begin
                status[ST_BP1:ST_BP0] <= {rx_sh[2:1]};
                status[ST_BPL]        <= rx_sh[6];
                status[ST_WEL]        <= 1'b0;
            end
        end
    end

    // sticky events, read data and interrupt line
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            irq_st <= '0;
            rdata  <= '0;
            irq    <= 1'b0;
        end
        else
        begin
            irq_st <= (irq_st & ~ev_clr) | ev_set;  // set wins
            rdata  <= rd ? rd_word : '0;
            irq    <= |(irq_st & irq_mask);
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_start_on_fall: assert property (
        (state == SFS_RUN) && $past(state == SFS_IDLE) |-> $past(cs_fall))
        else $error("frame started without select falling");
    a_byte_capture: assert property (
        byte_done |=> rx_data == $past({rx_sh, pin_s.si}))
        else $error("received byte not captured");
    a_so_on_fall: assert property (
        $changed(so) |-> $past(sck_fall) && $past(run))
        else $error("output changed off a falling clock");
    a_hold_clk_low: assert property (
        (state == SFS_HOLD) && $past(state == SFS_RUN) |-> !$past(pin_s.sck))
        else $error("pause entered with clock high");
    a_hold_tristate: assert property (
        (state == SFS_HOLD) [*2] |-> !so_oe)
        else $error("output driven while paused");
    a_hold_keeps: assert property (
        (state == SFS_HOLD) |=> $stable(bit_cnt) && $stable(rx_sh))
        else $error("pause lost link state");
    a_hold_deselect: assert property (
        (state == SFS_HOLD) && pin_s.cs_n |=> state == SFS_IDLE)
        else $error("deselect in pause did not reach standby");
    a_status_guard: assert property (
        st_spi_wr && !pin_s.wp_n && status[ST_BPL] |=> $stable(status[ST_BPL:ST_BP0]))
        else $error("locked status was written");
    a_prot_block: assert property (
        cmd_wr && prot_hit && !status[ST_BUSY] |=> !status[ST_BUSY])
        else $error("protected region write started");
    a_prog_time: assert property (
        op_go && (cmd == CMD_PROG) |-> ##70 status[ST_BUSY] ##1 !status[ST_BUSY])
        else $error("byte program busy time wrong");
    a_frame_drop: assert property (
        cs_fall |=> (bit_cnt == 3'h0) && (byte_cnt == 2'h0))
        else $error("partial command kept across select");
    a_ready_busy: assert property (
        run && sck_fall && ctrl[CT_AAI] && ctrl[CT_RBSO] |=> so == !$past(status[ST_BUSY]))
        else $error("ready/busy view wrong");
endmodule

/* File: verilog/sfs_pkg.sv */
// sfs_pkg: constants and types of the serial flash front end
// assumes a 10 MHz system clock and an 18-bit byte address space
package sfs_pkg;
    localparam int CLK_HZ   = 10_000_000;      // system clock rate
    localparam int T_CHIP_MS = 35;             // chip erase busy time, ms
    localparam int T_BLK_MS  = 18;             // sector/block erase busy time, ms
    localparam int T_PROG_US = 7;              // byte program busy time, us
    localparam int CYC_CHIP = T_CHIP_MS * (CLK_HZ / 1000);
    localparam int CYC_BLK  = T_BLK_MS * (CLK_HZ / 1000);
    localparam int CYC_PROG = T_PROG_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W    = 19;              // busy counter width
    localparam int ADR_W    = 18;              // byte address width

    // register offsets
    localparam logic [7:0] OFS_RXD  = 8'h00;   // last received byte
    localparam logic [7:0] OFS_TXD  = 8'h04;   // byte to shift out
    localparam logic [7:0] OFS_STAT = 8'h08;   // flash status byte
    localparam logic [7:0] OFS_CMD  = 8'h0c;   // internal operation start
    localparam logic [7:0] OFS_CTRL = 8'h10;   // mode control
    localparam logic [7:0] OFS_IRQ  = 8'h14;   // sticky events, read clears
    localparam logic [7:0] OFS_MASK = 8'h18;   // event mask
    localparam logic [7:0] OFS_BASE = 8'h1c;   // aligned base of last op
    localparam logic [7:0] OFS_LINK = 8'h20;   // link state view

    // status bit positions and value after reset
    localparam int ST_BUSY = 0;
    localparam int ST_WEL  = 1;
    localparam int ST_BP0  = 2;
    localparam int ST_BP1  = 3;
    localparam int ST_AAI  = 6;
    localparam int ST_BPL  = 7;
    localparam logic [7:0] ST_RESET = 8'h0c;

    // command field of OFS_CMD; address sits in bits 25:8
    localparam logic [2:0] CMD_PROG = 3'h1;
    localparam logic [2:0] CMD_SECT = 3'h2;
    localparam logic [2:0] CMD_B32  = 3'h3;
    localparam logic [2:0] CMD_B64  = 3'h4;
    localparam logic [2:0] CMD_CHIP = 3'h5;
    localparam logic [2:0] CMD_WREN = 3'h6;
    localparam logic [2:0] CMD_WRDI = 3'h7;
    localparam int CMD_ADR_LSB = 8;

    // erase granularity masks
    localparam logic [17:0] MASK_4K  = 18'h0_0fff;
    localparam logic [17:0] MASK_32K = 18'h0_7fff;
    localparam logic [17:0] MASK_64K = 18'h0_ffff;

    // control bits
    localparam int CT_AAI  = 0;                // auto_increment_program mode
    localparam int CT_RBSO = 1;                // ready_busy_out on serial output

    // event bits
    localparam int EV_START = 0;
    localparam int EV_BYTE  = 1;
    localparam int EV_END   = 2;
    localparam int EV_DONE  = 3;
    localparam int EV_STREF = 4;
    localparam int EV_OPREF = 5;
    localparam int EV_W     = 6;

    // synchronised pin group
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } sfs_pins_s;
    localparam sfs_pins_s PIN_RESET = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                                        hold_n: 1'b1, wp_n: 1'b1};

    typedef enum logic [1:0] {SFS_IDLE, SFS_RUN, SFS_HOLD} sfs_link_e;
endpackage

/* File: tb/sfs_host_model.sv */
// sfs_host_model: link host that frames bytes toward the flash front end
// assumes clk_sys at 10 MHz; the link clock half period is four cycles (400 ns)
`timescale 1ns/1ps
module sfs_host_model
    import sfs_pkg::*;
(
    input  wire logic       clk_sys,
    output logic            cs_n,
    output logic            sck,
    output logic            si,
    output logic            hold_n,
    input  wire logic       so,
    input  wire logic       so_oe
);
    logic       mode3;     // 1: clock idles high
    logic [7:0] rx;        // last eight bits seen on so
    logic       oe_before; // so_oe while pause pends with clock high
    logic       so_line;   // so as seen on the wire; a released line reads inverted

    // undriven output must not look like valid data
    assign so_line = so_oe ? so : ~so;

    // idle link at time zero
    initial
    begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        hold_n = 1'b1;
        mode3  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // clock parked at its idle level before select falls
    task automatic start(input logic m3);
        mode3 = m3;
        sck <= m3;
        wait_clk(4);
        cs_n <= 1'b0;
        wait_clk(4);
    endtask

    // top n bits of d, msb first; so read mid high phase
    task automatic xfer(input logic [7:0] d, input int n);
        for (int i = 0; i < n; i++)
        begin
            sck <= 1'b0;
            si  <= d[7-i];
            wait_clk(4);
            sck <= 1'b1;
            wait_clk(2);
            @(negedge clk_sys);
            rx = {rx[6:0], so_line};
            wait_clk(2);
        end
    endtask

    // select released; data line no longer shows the last bit
    task automatic stop();
        if (!mode3)
        begin
            sck <= 1'b0;
            wait_clk(4);
        end
        cs_n <= 1'b1;
        si   <= ~si;
        wait_clk(4);
    endtask

    // pause asked with clock high, clock then goes low
    task automatic hold_on();
        hold_n <= 1'b0;
        wait_clk(4);
        @(negedge clk_sys);
        oe_before = so_oe;
        wait_clk(1);
        sck <= 1'b0;
        wait_clk(6);
    endtask

    // clock and data move while paused
    task automatic wiggle();
        sck <= 1'b1;
        si  <= ~si;
        wait_clk(4);
        sck <= 1'b0;
        wait_clk(4);
    endtask

    task automatic hold_off();
        hold_n <= 1'b1;
        wait_clk(6);
    endtask
endmodule

/* File: tb/sfs_front_end_tb_top.sv */
// sfs_front_end_tb_top: self-checking bench of the flash front end
// assumes short busy counts (200 erase, 300 chip) and a host model on the link
`timescale 1ns/1ps
module sfs_front_end_tb_top
    import sfs_pkg::*;
;
    localparam logic [7:0] WSR = 8'h01; // opcode of write_status_cmd
    logic        clk_sys;      // 10 MHz clock
    logic        rst;          // async reset
    logic        cs_n;         // link pins
    logic        sck;
    logic        si;
    logic        hold_n;
    logic        wp_n;         // write guard pin
    logic        so;
    logic        so_oe;
    logic [7:0]  addr;         // register bus
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        irq;
    logic        rd_d = 1'b0;  // read issued last cycle
    logic [31:0] exp_q[$];     // expected read words
    logic [31:0] msk_q[$];     // bits that matter
    int          err_count;
    int          n_checks;
    logic [7:0]  tx;
    logic [7:0]  d;
    logic [17:0] a;
    logic [2:0]  ops [3] = '{CMD_SECT, CMD_B32, CMD_B64};
    logic [17:0] msks [3] = '{MASK_4K, MASK_32K, MASK_64K};

    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    sfs_front_end #(.CHIP_CYC(300), .BLK_CYC(200), .STATUS_WR_OP(WSR)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

    sfs_host_model u_host (
        .clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .so(so), .so_oe(so_oe));

    task automatic tally_and_finish();
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] g,
                         input logic [31:0] m);
        n_checks++;
        if ((g & m) !== (e & m))
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, e & m, g & m);
        end
    endtask

    task automatic cmp1(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s: expected %b, seen %b", what, e, g);
        end
    endtask

    task automatic wr_reg(input logic [7:0] ad, input logic [31:0] dv);
        addr  <= ad;
        wdata <= dv;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    // note the expectation, then issue the read
    task automatic rd_reg(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic frame(input logic m3, input logic [7:0] b0, input logic [7:0] b1,
                         input bit two);
        u_host.start(m3);
        u_host.xfer(b0, 8);
        if (two)
            u_host.xfer(b1, 8);
        u_host.stop();
    endtask

    task automatic cmd(input logic [2:0] op, input logic [17:0] ad);
        wr_reg(OFS_CMD, {29'h0, CMD_WREN});
        wr_reg(OFS_CMD, {6'h0, ad, 5'h0, op});
    endtask

    // read data checked mid cycle after the read
    always @(posedge clk_sys) rd_d <= rd;
    always @(negedge clk_sys)
    begin
        if (rd_d && exp_q.size() > 0)
            cmp32("rdata", exp_q.pop_front(), rdata, msk_q.pop_front());
    end

    // hang guard
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        rst = 1'b1; wp_n = 1'b1; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
        err_count = 0;
        n_checks = 0;
        void'($urandom(32'h2cca));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd_reg(OFS_STAT, {24'h0, ST_RESET}, 32'h0000_00ff);
        rd_reg(8'hfc, 32'h0, 32'hffff_ffff);
        cmp1("irq", 1'b0, irq);
        frame(1'b0, WSR, 8'h00, 1'b1);
        rd_reg(OFS_STAT, 32'h0, 32'h0000_00ff);
        // mode 3 byte and mode 0 second byte, both ways
        tx = 8'($urandom);
        d  = 8'($urandom);
        wr_reg(OFS_TXD, {24'h0, tx});
        frame(1'b1, d, 8'h00, 1'b0);
        cmp32("so byte", {24'h0, tx}, {24'h0, u_host.rx}, 32'hff);
        rd_reg(OFS_RXD, {24'h0, d}, 32'hff);
        tx = 8'($urandom);
        d  = 8'($urandom);
        wr_reg(OFS_TXD, {24'h0, tx});
        frame(1'b0, 8'h0b, d, 1'b1);
        cmp32("so byte", {24'h0, tx}, {24'h0, u_host.rx}, 32'hff);
        rd_reg(OFS_RXD, {24'h0, d}, 32'hff);
        // pause in mid byte, clock moving meanwhile
        d = 8'($urandom);
        u_host.start(1'b0);
        u_host.xfer(d, 4);
        u_host.hold_on();
        cmp1("so_oe before pause", 1'b1, u_host.oe_before);
        cmp1("so_oe", 1'b0, so_oe);
        rd_reg(OFS_LINK, 32'h2, 32'h3);
        u_host.wiggle();
        u_host.hold_off();
        u_host.xfer({d[3:0], 4'h0}, 4);
        u_host.stop();
        rd_reg(OFS_RXD, {24'h0, d}, 32'hff);
        // deselect while paused
        u_host.start(1'b0);
        u_host.xfer(8'h00, 2);
        u_host.hold_on();
        u_host.stop();
        rd_reg(OFS_LINK, 32'h0, 32'h3);
        u_host.hold_off();
        // partial byte dropped
        u_host.start(1'b0);
        u_host.xfer(8'hff, 3);
        u_host.stop();
        frame(1'b0, 8'h81, 8'h00, 1'b0);
        rd_reg(OFS_RXD, 32'h81, 32'hff);
        // program timing, interrupt raise and clear
        wr_reg(OFS_MASK, 32'h1 << EV_DONE);
        rd_reg(OFS_IRQ, 32'h7, 32'h3f);
        cmp1("irq", 1'b0, irq);
        cmd(CMD_PROG, 18'h0);
        rd_reg(OFS_STAT, 32'h1, 32'h1);
        repeat (60) @(posedge clk_sys);
        rd_reg(OFS_STAT, 32'h1, 32'h1);
        repeat (10) @(posedge clk_sys);
        rd_reg(OFS_STAT, 32'h0, 32'h3);
        cmp1("irq", 1'b1, irq);
        rd_reg(OFS_IRQ, 32'h1 << EV_DONE, 32'h1 << EV_DONE);
        repeat (3) @(posedge clk_sys);
        cmp1("irq", 1'b0, irq);
        // erase sizes and aligned base
        for (int k = 0; k < 3; k++)
        begin
            a = 18'($urandom);
            cmd(ops[k], a);
            rd_reg(OFS_BASE, {14'h0, a & ~msks[k]}, 32'h3_ffff);
            repeat (190) @(posedge clk_sys);
            rd_reg(OFS_STAT, 32'h1, 32'h1);
            repeat (25) @(posedge clk_sys);
            rd_reg(OFS_STAT, 32'h0, 32'h3);
        end
        // ready/busy shown on so
        wr_reg(OFS_CTRL, 32'h0000_0003);
        cmd(CMD_SECT, 18'h0);
        frame(1'b0, 8'h0b, 8'h00, 1'b1);
        cmp32("ready_busy_out", 32'h00, {24'h0, u_host.rx}, 32'hff);
        repeat (200) @(posedge clk_sys);
        frame(1'b0, 8'h0b, 8'h00, 1'b1);
        cmp32("ready_busy_out", 32'hff, {24'h0, u_host.rx}, 32'hff);
        wr_reg(OFS_CTRL, 32'h0);
        // protected array refuses program
        frame(1'b0, WSR, 8'h0c, 1'b1);
        rd_reg(OFS_IRQ, 32'hf, 32'h3f);
        cmd(CMD_PROG, 18'h0);
        rd_reg(OFS_STAT, 32'h0c, 32'h0d);
        rd_reg(OFS_IRQ, 32'h1 << EV_OPREF, 32'h1 << EV_OPREF);
        // chip erase refused while any protect bit is set
        cmd(CMD_CHIP, 18'h0);
        rd_reg(OFS_STAT, 32'h0e, 32'h0f);
        // lock bit gated by the guard pin
        frame(1'b0, WSR, 8'h8c, 1'b1);
        wp_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        frame(1'b0, WSR, 8'h00, 1'b1);
        rd_reg(OFS_STAT, 32'h8c, 32'hff);
        rd_reg(OFS_IRQ, 32'h1 << EV_STREF, 32'h1 << EV_STREF);
        wp_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        frame(1'b0, WSR, 8'h00, 1'b1);
        rd_reg(OFS_STAT, 32'h00, 32'hff);
        // write disable blocks chip erase, then chip erase busy time
        wr_reg(OFS_CMD, {29'h0, CMD_WREN});
        wr_reg(OFS_CMD, {29'h0, CMD_WRDI});
        wr_reg(OFS_CMD, {29'h0, CMD_CHIP});
        rd_reg(OFS_STAT, 32'h0, 32'h3);
        cmd(CMD_CHIP, 18'h0);
        repeat (290) @(posedge clk_sys);
        rd_reg(OFS_STAT, 32'h3, 32'h3);
        repeat (10) @(posedge clk_sys);
        rd_reg(OFS_STAT, 32'h0, 32'h3);
        repeat (4) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule
